// ---- rtl/sec_engine.sv ----
// Contract
// - Write-disable with eight clocks clears latch.
// - Write-disable with other clock count ignored.
// - Latch cleared at reset, disable, write end.
// - Status read repeats status byte until deselect.
// - Status read accepted even while busy.
// - Latch and busy live during write.
// - Status write changes lock and protect only.
// - Status write ignored unless latch set.
// - Status write runs after deselect, busy set.
// - Status write needs exactly sixteen clocks.
// - Hardware lock blocks status write.
// - Old protect values kept until write ends.
// - Read loads address, shifts addressed byte out.
// - Read address increments and wraps to zero.
// - Address bits beyond capacity are ignored.
// - Read ends on deselect, refused while busy.
// - Memory write starts on deselect at byte boundary.
// - Page write wraps low five address bits.
// - Memory write refused: no latch, busy, protected.
// - Memory write needs 24 plus 8m clocks.
// - One-byte opcodes, invalid opcode ignored until deselect.
// - Sample on rising, drive on falling edge.
// - Status byte lock, protect, latch, busy layout.
// - Lock bit plus low protect pin locks status.
`timescale 1ns/1ns
`include "sec_params.svh"

module sec_engine
#(
  parameter int ADDR_W = `SEC_ADDR_W,
  parameter int WRITE_CYC = `SEC_WRITE_CYC
)
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial link from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Write protect pin
  input wire logic wp_n
);
  import sec_pkg::*;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGE = 1 << `SEC_PAGE_BITS;
  localparam logic [15:0] ADDR_MASK = 16'(DEPTH - 1);
  localparam logic [19:0] WRITE_LAST = 20'(WRITE_CYC - 1);
  localparam logic [5:0] PAGE_LAST = 6'(PAGE - 1);
  localparam logic [2:0] NV_RESET = `SEC_NV_RESET;

  localparam sec_sys_t SYS_RESET = '{
    cs_meta: 1'b1,
    cs_sync: 1'b1,
    cs_prev: 1'b1,
    wp_meta: 1'b1,
    wp_sync: 1'b1,
    state: SEC_IDLE,
    write_latch_bit: 1'b0,
    status_lock_bit: NV_RESET[2],
    block_protect_hi: NV_RESET[1],
    block_protect_lo: NV_RESET[0],
    pend: NV_RESET,
    is_status: 1'b0,
    timer: 20'h00000,
    idx: 6'h00,
    mask: 32'h00000000,
    base: 16'h0000
  };

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Memory array is written on sys_clk and read on the link side; the read
  // side never sees a write in flight because reads are refused while busy.
  logic [7:0] mem [DEPTH];
  // Page staging buffer, filled on the link side, drained on sys_clk.
  logic [7:0] page [PAGE];

  sec_sys_t s;
  sec_sys_t next_s;
  sec_link_t lk;
  sec_link_t next_lk;
  logic active;
  logic busy;
  logic hw_lock;
  logic frame_end;
  logic protected_hit;
  logic [7:0] status_live;
  logic pg_we;
  logic [4:0] pg_idx;
  logic out_bit;
  logic drive;
  logic [2:0] bit_sel;

  // ----------------------------------------------------------------------
  // System clock side
  // ----------------------------------------------------------------------
  assign busy = (s.state != SEC_IDLE);
  assign hw_lock = s.status_lock_bit & ~s.wp_sync;
  assign frame_end = s.cs_sync & ~s.cs_prev;

  always_comb
  begin
    status_live = 8'h00;
    status_live[`SEC_BIT_LOCK] = s.status_lock_bit;
    status_live[`SEC_BIT_BP_HI] = s.block_protect_hi;
    status_live[`SEC_BIT_BP_LO] = s.block_protect_lo;
    status_live[`SEC_BIT_LATCH] = s.write_latch_bit;
    status_live[`SEC_BIT_BUSY] = busy;
  end

  // Protected region from the two protect bits: quarter, half or all.
  always_comb
  begin
    unique case ({s.block_protect_hi, s.block_protect_lo})
      2'b00: protected_hit = 1'b0;
      2'b01: protected_hit = &lk.start[ADDR_W-1 -: 2];
      2'b10: protected_hit = lk.start[ADDR_W-1];
      2'b11: protected_hit = 1'b1;
    endcase
  end

  // Frame results are read only after cs_n has risen and passed the
  // synchroniser; the link side is frozen then because sck is idle.
  always_comb
  begin
    next_s = s;
    next_s.cs_meta = cs_n;
    next_s.cs_sync = s.cs_meta;
    next_s.cs_prev = s.cs_sync;
    next_s.wp_meta = wp_n;
    next_s.wp_sync = s.wp_meta;
    unique case (s.state)
      SEC_IDLE:
      begin
        if (frame_end && !lk.refused)
        begin
          unique case (lk.opcode)
            SEC_WRITE_ENABLE_CMD:
            begin
              if (lk.cnt == `SEC_CNT_OPCODE)
                next_s.write_latch_bit = 1'b1;
            end
            SEC_WRITE_DISABLE_CMD:
            begin
              if (lk.cnt == `SEC_CNT_OPCODE)
                next_s.write_latch_bit = 1'b0;
            end
            SEC_STATUS_WRITE_CMD:
            begin
              if (lk.cnt == `SEC_CNT_STATUS && s.write_latch_bit
                  && !hw_lock)
              begin
                next_s.pend = {lk.stat[`SEC_BIT_LOCK],
                               lk.stat[`SEC_BIT_BP_HI],
                               lk.stat[`SEC_BIT_BP_LO]};
                next_s.is_status = 1'b1;
                next_s.timer = 20'h00000;
                next_s.state = SEC_PROG;
              end
            end
            SEC_MEM_WRITE_CMD:
            begin
              if (lk.cnt >= `SEC_CNT_DATA1 && lk.cnt[2:0] == 3'h0
                  && s.write_latch_bit && !protected_hit)
              begin
                next_s.mask = lk.mask;
                next_s.base = lk.start & ADDR_MASK;
                next_s.idx = 6'h00;
                next_s.is_status = 1'b0;
                next_s.timer = 20'h00000;
                next_s.state = SEC_COPY;
              end
            end
            default:
            begin
              next_s.state = SEC_IDLE;
            end
          endcase
        end
      end
      SEC_COPY:
      begin
        // One staged byte per cycle; the copy fits inside the write time.
        next_s.idx = s.idx + 6'h01;
        next_s.timer = s.timer + 20'h00001;
        if (s.idx == PAGE_LAST)
          next_s.state = SEC_PROG;
      end
      SEC_PROG:
      begin
        next_s.timer = s.timer + 20'h00001;
        if (s.timer >= WRITE_LAST)
        begin
          next_s.write_latch_bit = 1'b0;
          if (s.is_status)
          begin
            next_s.status_lock_bit = s.pend[2];
            next_s.block_protect_hi = s.pend[1];
            next_s.block_protect_lo = s.pend[0];
          end
          next_s.state = SEC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      s <= SYS_RESET;
    else
      s <= next_s;
  end

  // Commit the staged page; untouched slots keep their old contents.
  always_ff @(posedge sys_clk)
  begin
    if (s.state == SEC_COPY && s.mask[s.idx[4:0]])
      mem[{s.base[ADDR_W-1:`SEC_PAGE_BITS], s.idx[4:0]}] <= page[s.idx[4:0]];
  end

  // ----------------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------------
  // Frame marker: cleared by the deselect itself, so no sck edge is needed
  // to end a frame.
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
      active <= 1'b0;
    else
      active <= 1'b1;
  end

  always_comb
  begin
    next_lk = lk;
    pg_we = 1'b0;
    pg_idx = lk.cur[4:0];
    next_lk.sh = {lk.sh[6:0], si};
    if (!active)
    begin
      next_lk.cnt = 16'h0001;
      next_lk.mask = 32'h00000000;
      next_lk.refused = 1'b0;
    end
    else if (lk.cnt != `SEC_CNT_MAX)
    begin
      next_lk.cnt = lk.cnt + 16'h0001;
    end
    next_lk.bsy_meta = busy;
    next_lk.bsy_sync = lk.bsy_meta;
    next_lk.st_meta = status_live;
    next_lk.st_sync = lk.st_meta;
    if (next_lk.cnt == `SEC_CNT_OPCODE)
    begin
      next_lk.opcode = next_lk.sh;
      unique case (next_lk.sh)
        SEC_STATUS_READ_CMD:
          next_lk.refused = 1'b0;
        SEC_WRITE_ENABLE_CMD, SEC_WRITE_DISABLE_CMD,
        SEC_STATUS_WRITE_CMD, SEC_MEM_READ_CMD, SEC_MEM_WRITE_CMD:
          next_lk.refused = lk.bsy_sync;
        default:
          next_lk.refused = 1'b1;
      endcase
    end
    if (next_lk.cnt == `SEC_CNT_STATUS)
    begin
      next_lk.addr_hi = next_lk.sh;
      next_lk.stat = next_lk.sh;
    end
    if (next_lk.cnt == `SEC_CNT_ADDR)
    begin
      next_lk.cur = {lk.addr_hi, next_lk.sh} & ADDR_MASK;
      next_lk.start = {lk.addr_hi, next_lk.sh} & ADDR_MASK;
    end
    if (next_lk.cnt > `SEC_CNT_ADDR && next_lk.cnt[2:0] == 3'h0)
    begin
      if (lk.opcode == SEC_MEM_READ_CMD)
      begin
        next_lk.cur = (lk.cur + 16'h0001) & ADDR_MASK;
      end
      else if (lk.opcode == SEC_MEM_WRITE_CMD && !lk.refused)
      begin
        pg_we = 1'b1;
        next_lk.mask[lk.cur[4:0]] = 1'b1;
        next_lk.cur = {lk.cur[15:5], lk.cur[4:0] + 5'h01};
      end
    end
  end

  // Link state is not reset: frame start reinitialises what must restart.
  always_ff @(posedge sck)
  begin
    lk <= next_lk;
  end

  // Staging write; a byte sent twice to one slot keeps the later value.
  always_ff @(posedge sck)
  begin
    if (pg_we)
      page[pg_idx] <= next_lk.sh;
  end

  // ----------------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------------
  assign bit_sel = 3'h7 - lk.cnt[2:0];

  // status byte repeats each eight clocks
  // addressed byte follows address
  // The data bit is parked low while not driving, so the first frame's unknown
  // opcode never reaches the pin; an unwritten cell being read still does.
  always_comb
  begin
    drive = !lk.refused && active
      && ((lk.opcode == SEC_STATUS_READ_CMD
           && lk.cnt >= `SEC_CNT_OPCODE)
          || (lk.opcode == SEC_MEM_READ_CMD
              && lk.cnt >= `SEC_CNT_ADDR));
    if (!drive)
      out_bit = 1'b0;
    else if (lk.opcode == SEC_STATUS_READ_CMD)
      out_bit = lk.st_sync[bit_sel];
    else
      out_bit = mem[lk.cur[ADDR_W-1:0]][bit_sel];
  end

  // deselect ends the read at once
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so <= out_bit;
      so_oe <= drive;
    end
  end

endmodule : sec_engine

// ---- rtl/sec_params.svh ----
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// System clock rate in MHz.
`define SEC_CLK_MHZ 50
// Longest internal write time, in microseconds.
`define SEC_WRITE_TIME_US 5000
// Internal write time in system clock cycles.
`define SEC_WRITE_CYC (`SEC_WRITE_TIME_US * `SEC_CLK_MHZ)

// ----------------------------------------------------------------------
// Status byte field positions
// ----------------------------------------------------------------------
`define SEC_BIT_LOCK 7
`define SEC_BIT_BP_HI 3
`define SEC_BIT_BP_LO 2
`define SEC_BIT_LATCH 1
`define SEC_BIT_BUSY 0

// ----------------------------------------------------------------------
// Frame clock counts
// ----------------------------------------------------------------------
`define SEC_CNT_OPCODE 16'h0008
`define SEC_CNT_STATUS 16'h0010
`define SEC_CNT_ADDR 16'h0018
`define SEC_CNT_DATA1 16'h0020
`define SEC_CNT_MAX 16'hFFFF

// ----------------------------------------------------------------------
// Geometry and reset values
// ----------------------------------------------------------------------
`define SEC_ADDR_W 13
`define SEC_PAGE_BITS 5
// Lock and both protect bits cleared, as delivered.
`define SEC_NV_RESET 3'h0

`endif

// ---- rtl/sec_pkg.sv ----
`include "sec_params.svh"

package sec_pkg;

  // --------------------------------------------------------------------
  // Instruction codes
  // --------------------------------------------------------------------
  typedef enum logic [7:0] {
    SEC_WRITE_ENABLE_CMD = 8'h06,
    SEC_WRITE_DISABLE_CMD = 8'h04,
    SEC_STATUS_READ_CMD = 8'h05,
    SEC_STATUS_WRITE_CMD = 8'h01,
    SEC_MEM_READ_CMD = 8'h03,
    SEC_MEM_WRITE_CMD = 8'h02
  } sec_opcode_t;

  // --------------------------------------------------------------------
  // Internal write sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEC_IDLE = 3'b001,
    SEC_COPY = 3'b010,
    SEC_PROG = 3'b100
  } sec_state_t;

  // System clock side state.
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    sec_state_t state;
    logic write_latch_bit;
    logic status_lock_bit;
    logic block_protect_hi;
    logic block_protect_lo;
    logic [2:0] pend;
    logic is_status;
    logic [19:0] timer;
    logic [5:0] idx;
    logic [31:0] mask;
    logic [15:0] base;
  } sec_sys_t;

  // Serial clock side state.
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] sh;
    logic [7:0] opcode;
    logic [7:0] addr_hi;
    logic [15:0] cur;
    logic [15:0] start;
    logic [7:0] stat;
    logic [31:0] mask;
    logic refused;
    logic bsy_meta;
    logic bsy_sync;
    logic [7:0] st_meta;
    logic [7:0] st_sync;
  } sec_link_t;

endpackage : sec_pkg

// ---- test/sec_engine_chk.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Link pin checker
// ----------------------------------------------------------------------
module sec_chk
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic wp_n
);
  logic [7:0] cnt;
  logic [7:0] op;

  // Count rises per frame and keep the opcode; saturates on long reads.
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      cnt <= 8'h00;
      op <= 8'h00;
    end
    else
    begin
      if (cnt != 8'hFF)
        cnt <= cnt + 8'h01;
      if (cnt < 8'h08)
        op <= {op[6:0], si};
    end
  end

  chk_idle_quiet:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    cs_n |-> !so_oe && !so) else $error("so active while deselected");
  chk_so_steady:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!cs_n && sck && $past(sck)) |-> $stable(so) && $stable(so_oe))
    else $error("so moved while sck high");
  chk_oe_release:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(so_oe) |-> cs_n) else $error("so_oe fell inside frame");
  chk_opcode_quiet:
  assert property (@(negedge sck) disable iff (cs_n)
    cnt <= 8'h08 |-> !so_oe) else $error("so_oe during opcode");
  chk_status_drive:
  assert property (@(negedge sck) disable iff (cs_n)
    (op == 8'h05 && cnt >= 8'h09) |-> so_oe)
    else $error("status read not driven");
  chk_status_zeros:
  assert property (@(posedge sck) disable iff (cs_n)
    (op == 8'h05 && cnt >= 8'h08 && cnt[2:0] >= 3'h1 && cnt[2:0] <= 3'h3)
    |-> !so) else $error("status bit 6 to 4 set");
  chk_addr_quiet:
  assert property (@(negedge sck) disable iff (cs_n)
    (op == 8'h03 && cnt >= 8'h08 && cnt <= 8'h18) |-> !so_oe)
    else $error("so_oe during read address");
  chk_other_quiet:
  assert property (@(negedge sck) disable iff (cs_n)
    (cnt >= 8'h09 && op != 8'h05 && op != 8'h03) |-> !so_oe)
    else $error("so_oe for non read opcode");
endmodule : sec_chk

bind sec_engine sec_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
  .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n));

// ---- test/sec_host.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Host link controller model
// ----------------------------------------------------------------------
module sec_host
(
  // Link pins toward the device
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic lv;
  int oe_cnt;

  // Idle bus: clock parked low, device deselected. A brief select with no
  // clock gives the link flops a deselect edge that puts them at idle.
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    lv = 1'b0;
    oe_cnt = 0;
    #1 cs_n = 1'b1;
  end

  // framed transfer
  // Sends n bits MSB first from the top of tx; a floating so reads inverted.
  task automatic xfer(input int n, input logic [63:0] tx,
    output logic [63:0] rx);
    rx = 64'h0;
    oe_cnt = 0;
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si = tx[63 - i];
      #40 sck = 1'b1;
      lv = so_oe ? so : ~lv;
      // Counts the clocks at which the device drives; unknown counts too.
      if (so_oe !== 1'b0)
        oe_cnt++;
      rx = {rx[62:0], lv};
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask : xfer
endmodule : sec_host

// ---- test/sec_engine_tb.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Command engine testbench
// ----------------------------------------------------------------------
module sec_engine_tb;
  import sec_pkg::*;
  // Short write time keeps polling brief, yet long enough that a refused
  // read frame and a refused write frame both fall inside one write.
  localparam int WCYC = 300;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wp_n = 1'b1;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic [63:0] rx;
  int fail_count = 0;
  int comparisons = 0;

  // Free running system clock.
  always #10 sys_clk = ~sys_clk;

  sec_engine #(.ADDR_W(13), .WRITE_CYC(WCYC)) dut_u (.sys_clk(sys_clk),
    .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .wp_n(wp_n));
  sec_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));

  task automatic check(input string name, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cmd(input int n, input sec_opcode_t op,
    input logic [7:0] b);
    host_u.xfer(n, {op, b, 48'h0}, rx);
  endtask : cmd

  // Two status bytes in one frame must match.
  task automatic status_read_cmd(input logic [7:0] exp);
    host_u.xfer(24, {SEC_STATUS_READ_CMD, 56'h0}, rx);
    check("status", exp, rx[15:8]);
    check("status repeat", exp, rx[7:0]);
  endtask : status_read_cmd

  // Bounded poll of the busy flag; running out of polls is a mismatch.
  task automatic wait_idle;
    for (int i = 0; i < 40; i++)
    begin
      host_u.xfer(16, {SEC_STATUS_READ_CMD, 56'h0}, rx);
      if (rx[0] === 1'b0)
        break;
    end
    check("busy flag", 8'h00, {7'h00, rx[0]});
  endtask : wait_idle

  task automatic rd(input logic [15:0] a, input logic [7:0] e0,
    input logic [7:0] e1);
    host_u.xfer(40, {SEC_MEM_READ_CMD, a, 40'h0}, rx);
    check("read byte 0", e0, rx[15:8]);
    check("read byte 1", e1, rx[7:0]);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [23:0] d,
    input int n);
    host_u.xfer(n, {SEC_MEM_WRITE_CMD, a, d, 16'h0}, rx);
  endtask : wr

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    status_read_cmd(8'h00);
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    status_read_cmd(8'h02);
    host_u.xfer(24, {8'hFF, 56'h0}, rx);
    check("bad opcode drive", 8'h00, 8'(host_u.oe_cnt));
    cmd(9, SEC_WRITE_DISABLE_CMD, 8'h00);
    status_read_cmd(8'h02);
    cmd(8, SEC_WRITE_DISABLE_CMD, 8'h00);
    status_read_cmd(8'h00);
    cmd(16, SEC_STATUS_WRITE_CMD, 8'h8C);
    status_read_cmd(8'h00);
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    cmd(17, SEC_STATUS_WRITE_CMD, 8'hFF);
    status_read_cmd(8'h02);
    cmd(16, SEC_STATUS_WRITE_CMD, 8'hFF);
    host_u.xfer(16, {SEC_STATUS_READ_CMD, 56'h0}, rx);
    check("status busy", 8'h03, rx[7:0]);
    wait_idle();
    status_read_cmd(8'h8C);
    @(posedge sys_clk) wp_n <= 1'b0;
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    cmd(16, SEC_STATUS_WRITE_CMD, 8'h00);
    wait_idle();
    status_read_cmd(8'h8E);
    @(posedge sys_clk) wp_n <= 1'b1;
    cmd(16, SEC_STATUS_WRITE_CMD, 8'h00);
    wait_idle();
    status_read_cmd(8'h00);
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    wr(16'hE01E, 24'hA1A2A3, 48);
    host_u.xfer(32, {SEC_MEM_READ_CMD, 16'h001E, 40'h0}, rx);
    check("busy read drive", 8'h00, 8'(host_u.oe_cnt));
    wr(16'h0000, 24'h777777, 32);
    wait_idle();
    status_read_cmd(8'h00);
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    wr(16'h1FFF, 24'h5A0000, 32);
    wait_idle();
    rd(16'hFFFF, 8'h5A, 8'hA3);
    rd(16'hE01E, 8'hA1, 8'hA2);
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    cmd(16, SEC_STATUS_WRITE_CMD, 8'h04);
    wait_idle();
    status_read_cmd(8'h04);
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    wr(16'h1FFF, 24'h000000, 32);
    wait_idle();
    cmd(8, SEC_WRITE_ENABLE_CMD, 8'h00);
    wr(16'h0000, 24'hBB0000, 28);
    wait_idle();
    rd(16'h1FFF, 8'h5A, 8'hA3);
    print_verdict();
  end

  // Watchdog well beyond the expected run time.
  initial
  begin
    #1000000;
    fail_count++;
    print_verdict();
  end
endmodule : sec_engine_tb
